//--- shared/spc_pkg.sv
// Functional notes
// - reset or low-power entry clears control to 00
// - cpu reads and writes every control bit anytime
// - bit 7 gates transmit-empty request
// - transmit-empty request drops when flag or enable clears
// - bit 6 gates receive-full and receive-error requests
// - receive requests drop when flag or enable clears
// - transmit disabled holds transmit-empty flag at one
// - data write with transmit enabled clears empty flag, starts transmission
// - transmit pin serial only when port-mode bit set
// - receive pin serial only while receive enabled
// - receive disable leaves receive flags untouched
// - receive starts on start bit or clock
// - wake enable acts only async multiprocessor mode
// - wake enable suppresses reception until marked character
// - marked character sets flag, clears wake enable
// - bit 2 gates transmit-end request
// - transmit-end request drops when end flag or enable clears
// - clock select pair picks source and pin function
// - async clock output runs at bit rate
// - empty flag set on transfer or while transmit disabled, cleared on write while enabled
// - full flag set on clean reception transfer
package spc_pkg;
  // ==========================================================
  // register map, word index on the plain register port
  localparam int         ADDR_W     = 3;
  localparam logic [2:0] OFS_MODE   = 3'h0;
  localparam logic [2:0] OFS_RATE   = 3'h1;
  localparam logic [2:0] OFS_CTRL   = 3'h2;
  localparam logic [2:0] OFS_TXHOLD = 3'h3;
  localparam logic [2:0] OFS_STATUS = 3'h4;
  localparam logic [2:0] OFS_RXHOLD = 3'h5;
  localparam logic [2:0] OFS_PORT   = 3'h6;
  // ==========================================================
  // values after reset
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] RATE_RST   = 8'h00;
  localparam logic [7:0] TXHOLD_RST = 8'hFF;
  localparam logic [7:0] RXHOLD_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h84;
  localparam logic [7:0] PORT_RST   = 8'h00;
  // ==========================================================
  // status field positions that software may clear
  localparam int ST_CLR_LO = 3;
  localparam int ST_CLR_HI = 7;
  // ==========================================================
  // timing counts
  localparam logic [3:0] OVS_LAST  = 4'hF;  // sixteen ticks per async bit
  localparam logic [3:0] OVS_MID   = 4'h7;  // middle of the start bit
  localparam logic [3:0] SYNC_BITS = 4'h8;  // clocked mode character
  // ==========================================================
  // register layouts
  typedef struct packed {
    logic tx_empty_irq_en;
    logic rx_irq_en;
    logic transmit_enable;
    logic receive_enable;
    logic multiproc_wake_irq_en;
    logic tx_end_irq_en;
    logic clock_sel_hi;
    logic clock_sel_lo;
  } spc_ctrl_t;
  typedef struct packed {
    logic       sync_mode;
    logic       char7;
    logic       parity_en;
    logic       parity_odd;
    logic       two_stop;
    logic       multiproc_mode;
    logic [1:0] clk_div;
  } spc_mode_t;
  typedef struct packed {
    logic tx_empty_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_flag;
    logic parity_flag;
    logic tx_end_flag;
    logic rx_multiproc_bit;
    logic tx_multiproc_bit;
  } spc_stat_t;
  typedef struct packed {
    logic tx_empty_request;
    logic rx_full_request;
    logic rx_error_request;
    logic tx_end_request;
  } spc_req_t;
  // ==========================================================
  // state encodings
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SHIFT = 2'b01
  } spc_tx_st_t;
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10
  } spc_rx_st_t;
endpackage

//--- src/spc_sync3.sv
`timescale 1ns/100ps
// three-stage pin synchroniser; output moves once stages two and three agree
module spc_sync3
  import spc_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // pin and clean level
  input  wire logic d,
  output logic      q
);
  logic s1;  // metastable stage, read only by s2
  logic s2;  // second stage
  logic s3;  // third stage

  // ==========================================================
  // shift chain plus agreement filter
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      q  <= RST_VAL;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      // a lone glitch between stages never reaches the output
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end
endmodule

//--- src/spc_serial_port.sv
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
// serial port control block with compact transmitter and receiver
module spc_serial_port
  import spc_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // low-power entry, same clock domain, clears control, mode, status and data registers like reset; rate keeps its value
  input  wire logic              lp_clear,
  // register port
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [7:0]        rdata,
  // serial pins
  input  wire logic              rxd_pin,
  output logic                   txd_o,
  output logic                   txd_serial,
  output logic                   rxd_serial,
  input  wire logic              sck_i,
  output logic                   sck_o,
  output logic                   sck_oe,
  // interrupt request levels
  output spc_req_t               req
);
  // ==========================================================
  // registers
  spc_ctrl_t  ctrl;        // serial_control
  spc_mode_t  mode;        // serial_mode
  spc_stat_t  stat;        // serial_status
  logic [7:0] rate;        // bit-rate divider
  logic [7:0] tx_holding;  // transmit data
  logic [7:0] rx_holding;  // received data
  logic       port_mode_7; // transmit pin selects serial function
  logic [4:0] clr_armed;   // flag read as one, may now be cleared

  // ==========================================================
  // address decode
  wire wr_ctrl = wr && (addr == OFS_CTRL);
  wire wr_mode = wr && (addr == OFS_MODE);
  wire wr_rate = wr && (addr == OFS_RATE);
  wire wr_tx   = wr && (addr == OFS_TXHOLD);
  wire wr_stat = wr && (addr == OFS_STATUS);
  wire wr_port = wr && (addr == OFS_PORT);
  wire rd_stat = rd && (addr == OFS_STATUS);
  wire rd_rx   = rd && (addr == OFS_RXHOLD);

  // ==========================================================
  // clock source
  logic        rx_sync;     // cleaned receive pin
  logic        sck_sync;    // cleaned clock pin
  logic        sck_prev;    // for edge finding
  logic [11:0] div_cnt;     // internal tick divider
  logic [3:0]  ovs_cnt;     // sixteenth-of-bit counter
  logic        sck_phase;   // clocked-mode internal clock level

  spc_sync3 #(.RST_VAL(1'b1)) u_rx_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       (rxd_pin),
    .q       (rx_sync)
  );
  spc_sync3 #(.RST_VAL(1'b0)) u_sck_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       (sck_i),
    .q       (sck_sync)
  );

  wire [3:0]  div_sh   = (mode.clk_div == 2'b00) ? 4'h0 :
                         (mode.clk_div == 2'b01) ? 4'h2 : 4'h4;
  wire [11:0] div_top  = ((12'(rate) + 12'h001) << div_sh) - 12'h001;
  wire        tick_int = (div_cnt == div_top);
  wire        sck_rise = sck_sync && !sck_prev;
  wire        ext_clk  = ctrl.clock_sel_hi;
  wire        tick16   = ext_clk ? sck_rise : tick_int;
  // clocked mode moves one bit per rising clock edge
  wire        sync_ev  = ext_clk ? sck_rise : (tick_int && !sck_phase);
  wire        bit_ev   = mode.sync_mode ? sync_ev : (tick16 && ovs_cnt == OVS_LAST);

  // divider and bit-phase counters
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_cnt   <= 12'h000;
      ovs_cnt   <= 4'h0;
      sck_phase <= 1'b0;
      sck_prev  <= 1'b0;
    end else begin
      div_cnt   <= tick_int ? 12'h000 : div_cnt + 12'h001;
      ovs_cnt   <= tick16 ? ovs_cnt + 4'h1 : ovs_cnt;
      sck_phase <= tick_int ? !sck_phase : sck_phase;
      sck_prev  <= sck_sync;
    end
  end

  // ==========================================================
  // frame shape shared by transmitter and receiver
  function automatic logic [3:0] frame_len(input spc_mode_t m);
    // data bits, parity or marker bit, first stop bit
    frame_len = (m.char7 ? 4'h7 : 4'h8) + 4'(m.parity_en || m.multiproc_mode) + 4'h1;
  endfunction

  // ==========================================================
  // transmitter
  spc_tx_st_t tx_st;
  logic [11:0] tx_sh;   // start bit first, shifted out at the bottom
  logic [3:0]  tx_left; // bits still to send
  logic [11:0] tx_frame;
  logic [3:0]  tx_len;
  wire         par_tx  = ^(mode.char7 ? {1'b0, tx_holding[6:0]} : tx_holding) ^ mode.parity_odd;
  wire         extra   = mode.multiproc_mode ? stat.tx_multiproc_bit : par_tx;
  wire         has_ext = mode.parity_en || mode.multiproc_mode;
  wire tx_load = (tx_st == TX_IDLE) && bit_ev && ctrl.transmit_enable && !stat.tx_empty_flag;
  wire tx_last = (tx_st == TX_SHIFT) && bit_ev && (tx_left == 4'h1);

  // build the outgoing character once, before it enters the shifter
  always_comb begin
    tx_frame = 12'hFFF;
    if (mode.sync_mode) begin
      tx_frame[7:0] = tx_holding;
      tx_len        = SYNC_BITS;
    end else begin
      tx_frame[0] = 1'b0;
      tx_frame[7:1] = tx_holding[6:0];
      if (mode.char7) begin
        tx_frame[8] = has_ext ? extra : 1'b1;
      end else begin
        tx_frame[8] = tx_holding[7];
        tx_frame[9] = has_ext ? extra : 1'b1;
      end
      tx_len = frame_len(mode) + 4'(mode.two_stop) + 4'h1;
    end
  end

  // shifter sequence
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_st   <= TX_IDLE;
      tx_sh   <= 12'hFFF;
      tx_left <= 4'h0;
      txd_o   <= 1'b1;
    end else if (lp_clear) begin
      tx_st   <= TX_IDLE;
      tx_sh   <= 12'hFFF;
      tx_left <= 4'h0;
      txd_o   <= 1'b1;
    end else begin
      case (tx_st)
        TX_IDLE: begin
          txd_o <= 1'b1;
          if (tx_load) begin
            tx_sh   <= tx_frame;
            tx_left <= tx_len;
            tx_st   <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (bit_ev) begin
            txd_o   <= tx_sh[0];
            tx_sh   <= {1'b1, tx_sh[11:1]};
            tx_left <= tx_left - 4'h1;
            if (tx_left == 4'h1) begin
              tx_st <= TX_IDLE;
            end
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // receiver
  spc_rx_st_t rx_st;
  logic [10:0] rx_sh;    // bits enter at the top
  logic [3:0]  rx_left;
  logic [3:0]  rx_ovs;
  logic        rx_done;  // character complete, judged next cycle
  wire         rx_line = ctrl.receive_enable ? rx_sync : 1'b1;
  wire [3:0]   rx_len  = mode.sync_mode ? SYNC_BITS : frame_len(mode);
  wire         rx_samp = mode.sync_mode ? sync_ev : (tick16 && rx_ovs == OVS_LAST);

  // start detection and bit sampling
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_st   <= RX_IDLE;
      rx_sh   <= 11'h000;
      rx_left <= 4'h0;
      rx_ovs  <= 4'h0;
      rx_done <= 1'b0;
    end else if (lp_clear) begin
      rx_st   <= RX_IDLE;
      rx_left <= 4'h0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_st)
        RX_IDLE: begin
          rx_ovs <= 4'h0;
          if (ctrl.receive_enable && mode.sync_mode && sync_ev) begin
            rx_sh   <= {rx_line, rx_sh[10:1]};
            rx_left <= SYNC_BITS - 4'h1;
            rx_st   <= RX_DATA;
          end else if (ctrl.receive_enable && !mode.sync_mode && tick16 && !rx_line) begin
            rx_st <= RX_START;
          end
        end
        RX_START: begin
          if (tick16) begin
            rx_ovs <= rx_ovs + 4'h1;
            if (rx_ovs == OVS_MID - 4'h1) begin
              // a start bit gone high by its middle was only noise
              rx_st   <= rx_line ? RX_IDLE : RX_DATA;
              rx_ovs  <= 4'h0;
              rx_left <= rx_len;
            end
          end
        end
        RX_DATA: begin
          if (tick16 && !mode.sync_mode) begin
            rx_ovs <= rx_ovs + 4'h1;
          end
          if (rx_samp) begin
            rx_sh   <= {rx_line, rx_sh[10:1]};
            rx_left <= rx_left - 4'h1;
            if (rx_left == 4'h1) begin
              rx_done <= 1'b1;
              rx_st   <= RX_IDLE;
            end
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // character fields, aligned down from the top of the shifter
  wire [10:0] rx_frm   = rx_sh >> (4'hB - rx_len);
  wire [7:0]  rx_data  = mode.char7 && !mode.sync_mode ? {1'b0, rx_frm[6:0]} : rx_frm[7:0];
  wire        rx_ext   = mode.char7 ? rx_frm[7] : rx_frm[8];
  wire        rx_stop  = rx_frm[rx_len - 4'h1];
  wire        mp_act   = !mode.sync_mode && mode.multiproc_mode;
  wire        mp_skip  = mp_act && ctrl.multiproc_wake_irq_en && !rx_ext;
  wire        mp_hit   = mp_act && rx_ext && rx_done;
  wire        rx_take  = rx_done && !mp_skip;
  wire        e_over   = rx_take && stat.rx_full_flag;
  wire        e_frame  = rx_take && !e_over && !mode.sync_mode && !rx_stop;
  wire        e_par    = rx_take && !e_over && !e_frame && !mp_act && !mode.sync_mode &&
                         mode.parity_en && ((^rx_data ^ rx_ext) != mode.parity_odd);
  wire        rx_good  = rx_take && !e_over && !e_frame && !e_par;

  // ==========================================================
  // status next values; every set is applied after its clear
  logic [4:0] sw_clr;
  spc_stat_t  next_stat;
  assign sw_clr = wr_stat ? (~wdata[ST_CLR_HI:ST_CLR_LO] & clr_armed) : 5'h00;

  always_comb begin
    next_stat = stat;
    // software clears: write zero after reading one; data write and data read clear too
    if (sw_clr[4] || wr_tx) next_stat.tx_empty_flag = 1'b0;
    if (sw_clr[3] || rd_rx) next_stat.rx_full_flag = 1'b0;
    if (sw_clr[2]) next_stat.overrun_flag = 1'b0;
    if (sw_clr[1]) next_stat.framing_flag = 1'b0;
    if (sw_clr[0]) next_stat.parity_flag = 1'b0;
    if (wr_tx) next_stat.tx_end_flag = 1'b0;
    if (wr_stat) next_stat.tx_multiproc_bit = wdata[0];
    // hardware sets
    if (tx_load || !ctrl.transmit_enable) next_stat.tx_empty_flag = 1'b1;
    if (tx_last && stat.tx_empty_flag && !wr_tx) next_stat.tx_end_flag = 1'b1;
    if (rx_good) next_stat.rx_full_flag = 1'b1;
    if (e_over) next_stat.overrun_flag = 1'b1;
    if (e_frame) next_stat.framing_flag = 1'b1;
    if (e_par) next_stat.parity_flag = 1'b1;
    if (rx_take && mp_act) next_stat.rx_multiproc_bit = rx_ext;
  end

  // ==========================================================
  // register writes; nothing here touches receive flags on enable changes
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RST;
      mode <= MODE_RST;
      rate <= RATE_RST;
      port_mode_7 <= PORT_RST[0];
      tx_holding  <= TXHOLD_RST;
    end else if (lp_clear) begin
      ctrl <= CTRL_RST;
      mode <= MODE_RST;
      port_mode_7 <= PORT_RST[0];
      tx_holding  <= TXHOLD_RST;
    end else begin
      if (wr_ctrl) ctrl <= spc_ctrl_t'(wdata);
      // the wake enable drops on a marked character, after any write
      if (mp_hit) ctrl.multiproc_wake_irq_en <= 1'b0;
      if (wr_mode) mode <= spc_mode_t'(wdata);
      if (wr_rate) rate <= wdata;
      if (wr_port) port_mode_7 <= wdata[0];
      if (wr_tx) tx_holding <= wdata;
    end
  end

  // flags, received data and clear arming
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      stat       <= STATUS_RST;
      rx_holding <= RXHOLD_RST;
      clr_armed  <= 5'h00;
    end else if (lp_clear) begin
      stat       <= STATUS_RST;
      rx_holding <= RXHOLD_RST;
      clr_armed  <= 5'h00;
    end else begin
      stat <= next_stat;
      // framing errors still deliver data; overruns lose it
      if (rx_good || e_frame || e_par) rx_holding <= rx_data;
      if (rd_stat) clr_armed <= clr_armed | stat[ST_CLR_HI:ST_CLR_LO];
      else if (wr_stat) clr_armed <= clr_armed & ~sw_clr;
    end
  end

  // ==========================================================
  // read port and registered pin and request outputs
  wire [7:0] rd_mux = (addr == OFS_CTRL)   ? ctrl :
                      (addr == OFS_MODE)   ? mode :
                      (addr == OFS_RATE)   ? rate :
                      (addr == OFS_TXHOLD) ? tx_holding :
                      (addr == OFS_STATUS) ? stat :
                      (addr == OFS_RXHOLD) ? rx_holding :
                      (addr == OFS_PORT)   ? {7'h00, port_mode_7} : 8'h00;
  wire sck_out_en = !ext_clk && (mode.sync_mode || ctrl.clock_sel_lo);
  wire sck_level  = mode.sync_mode ? sck_phase : ovs_cnt[3];

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata      <= 8'h00;
      txd_serial <= 1'b0;
      rxd_serial <= 1'b0;
      sck_o      <= 1'b0;
      sck_oe     <= 1'b0;
      req        <= '0;
    end else begin
      rdata      <= rd ? rd_mux : 8'h00;
      txd_serial <= port_mode_7;
      rxd_serial <= ctrl.receive_enable;
      sck_o      <= sck_out_en && sck_level;
      sck_oe     <= sck_out_en;
      req.tx_empty_request <= ctrl.tx_empty_irq_en && next_stat.tx_empty_flag;
      req.rx_full_request  <= ctrl.rx_irq_en && next_stat.rx_full_flag;
      req.rx_error_request <= ctrl.rx_irq_en && (next_stat.overrun_flag ||
                              next_stat.framing_flag || next_stat.parity_flag);
      req.tx_end_request   <= ctrl.tx_end_irq_en && next_stat.tx_end_flag;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_tx_write;
    wr_tx && ctrl.transmit_enable && !tx_load;
  endsequence

  chk_lp_clears_ctrl: assert property (lp_clear |=> ctrl == CTRL_RST)
    else $error("control not cleared by low-power entry");
  chk_ctrl_rw_back: assert property (wr_ctrl && !mp_hit && !lp_clear
    ##1 rd && addr == OFS_CTRL && !lp_clear |=> rdata == $past(wdata, 2))
    else $error("control read back differs from write");
  chk_tx_empty_req: assert property (##1 req.tx_empty_request ==
    $past(ctrl.tx_empty_irq_en && next_stat.tx_empty_flag))
    else $error("transmit-empty request wrong");
  chk_rx_req_drop: assert property (!ctrl.rx_irq_en |=> !req.rx_full_request && !req.rx_error_request)
    else $error("receive request while disabled");
  chk_tx_off_empty: assert property (!ctrl.transmit_enable && !lp_clear |=> stat.tx_empty_flag)
    else $error("empty flag low with transmit disabled");
  chk_tx_write_clear: assert property (s_tx_write and !lp_clear |=> !stat.tx_empty_flag)
    else $error("data write did not clear empty flag");
  chk_mp_wake_drop: assert property (mp_hit && !lp_clear |=> !ctrl.multiproc_wake_irq_en
    && stat.rx_multiproc_bit)
    else $error("marked character did not end wake wait");
  chk_mp_skip_quiet: assert property (rx_done && mp_skip && !stat.rx_full_flag && !lp_clear
    |=> !stat.rx_full_flag && $stable(rx_holding))
    else $error("unmarked character delivered during wake wait");
  chk_sck_ext_in: assert property (ctrl.clock_sel_hi |=> !sck_oe)
    else $error("clock pin driven with external clock");
  chk_txd_pin_fn: assert property (##1 txd_serial == $past(port_mode_7))
    else $error("transmit pin function wrong");
endmodule

//--- bench/spc_far_model.sv
`timescale 1ns/100ps
// remote serial sender that brings its own sixteen-times link clock
module spc_far_model (
  // link pins
  output logic rxd_pin,
  output logic sck_i
);
  // line idles at mark; the clock stands still outside frames
  initial begin
    rxd_pin = 1'b1;
    sck_i   = 1'b0;
  end
  // ==========================================================
  // one frame, lsb first, sixteen link clocks per bit
  task automatic send(input logic [10:0] frame, input int nbits);
    for (int b = 0; b < nbits; b++) begin
      rxd_pin = frame[b];
      // 125 ns link period, unrelated in phase to the system clock
      repeat (16) begin
        #62.5 sck_i = 1'b1;
        #62.5 sck_i = 1'b0;
      end
    end
    rxd_pin = 1'b1;
  endtask
endmodule

//--- bench/tb_serial_port_control_register.sv
`timescale 1ns/100ps
module tb_serial_port_control_register
  import spc_pkg::*;
;
  // ==========================================================
  // stimulus, observed pins and counters
  logic              clk_sys  = 1'b0;
  logic              rstn     = 1'b0;
  logic              lp_clear = 1'b0;
  logic [ADDR_W-1:0] addr     = 3'h0;
  logic [7:0]        wdata    = 8'h00;
  logic              wr       = 1'b0;
  logic              rd       = 1'b0;
  logic [7:0]        rdata, rv;
  logic              rxd_pin, sck_i, txd_o, txd_serial, rxd_serial, sck_o, sck_oe;
  spc_req_t          req;
  int                n_errors  = 0;
  int                cmp_count = 0;
  // requests on top, then txd_o, sck_oe, rxd_serial, txd_serial
  wire  [7:0]        obs = {req, txd_o, sck_oe, rxd_serial, txd_serial};
  always #5 clk_sys = ~clk_sys;
  spc_serial_port uut (.clk_sys(clk_sys), .rstn(rstn), .lp_clear(lp_clear), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd_pin(rxd_pin), .txd_o(txd_o),
    .txd_serial(txd_serial), .rxd_serial(rxd_serial), .sck_i(sck_i), .sck_o(sck_o),
    .sck_oe(sck_oe), .req(req));
  spc_far_model far (.rxd_pin(rxd_pin), .sck_i(sck_i));
  // ==========================================================
  // shared helpers
  task automatic end_sim;
    $display("mismatches %0d of %0d compares", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // strobe a cycle, then leave a cycle so no strobe is assigned twice at one edge
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk_sys); wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a);
    addr <= a; rd <= 1'b1;
    @(posedge clk_sys); rd <= 1'b0;
    #1 rv = rdata;
    @(posedge clk_sys);
  endtask
  // bounded wait on one observed pin; a run-out is a mismatch and ends the run
  task automatic wait_obs(input int i, input logic v, input int lim);
    // step off the edge so the value launched there is the one judged
    #1;
    for (int k = 0; k < lim && obs[i] !== v; k++) begin
      @(posedge clk_sys); #1;
    end
    check(obs[i], v);
    if (obs[i] !== v) end_sim;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd_reg(OFS_CTRL); check(rv, 8'h00);
    rd_reg(OFS_STATUS); check(rv, 8'h84);
    check(rxd_serial, 1'b0);
    check(txd_serial, 1'b0);
  endtask
  task automatic t_rw;
    wr_reg(OFS_CTRL, 8'hA5); rd_reg(OFS_CTRL); check(rv, 8'hA5);
    wr_reg(OFS_CTRL, 8'h5A); rd_reg(OFS_CTRL); check(rv, 8'h5A);
    // write then read with no gap between the strobes
    addr <= OFS_CTRL; wdata <= 8'h3C; wr <= 1'b1;
    @(posedge clk_sys); wr <= 1'b0; rd <= 1'b1;
    @(posedge clk_sys); rd <= 1'b0;
    #1 check(rdata, 8'h3C);
    @(posedge clk_sys);
    lp_clear <= 1'b1;
    @(posedge clk_sys); lp_clear <= 1'b0;
    @(posedge clk_sys);
    rd_reg(OFS_CTRL); check(rv, 8'h00);
  endtask
  task automatic t_irq;
    wr_reg(OFS_CTRL, 8'h80); wait_obs(7, 1'b1, 4);
    wr_reg(OFS_CTRL, 8'h00); wait_obs(7, 1'b0, 4);
    wr_reg(OFS_CTRL, 8'h04); wait_obs(4, 1'b1, 4);
    wr_reg(OFS_CTRL, 8'h00); wait_obs(4, 1'b0, 4);
  endtask
  task automatic t_tx;
    // a data write while transmit is off must not drop the empty flag
    wr_reg(OFS_TXHOLD, 8'h55); rd_reg(OFS_STATUS); check(rv[7], 1'b1);
    wr_reg(OFS_PORT, 8'h01); wr_reg(OFS_MODE, 8'h00);
    wr_reg(OFS_CTRL, 8'h20); wait_obs(0, 1'b1, 4);
    wr_reg(OFS_TXHOLD, 8'hA5); wait_obs(3, 1'b0, 40);
    wr_reg(OFS_PORT, 8'h00); wait_obs(0, 1'b0, 4);
    wr_reg(OFS_CTRL, 8'h00);
  endtask
  task automatic t_clk;
    wr_reg(OFS_CTRL, 8'h01); wait_obs(2, 1'b1, 4);
    // rate zero ticks every clock: sixteen per bit, so the pin is low eight clocks
    for (int k = 0; k < 20 && sck_o !== 1'b1; k++) begin @(posedge clk_sys); #1; end
    for (int k = 0; k < 20 && sck_o === 1'b1; k++) begin @(posedge clk_sys); #1; end
    repeat (8) begin check(sck_o, 1'b0); @(posedge clk_sys); #1; end
    check(sck_o, 1'b1);
    wr_reg(OFS_CTRL, 8'h00); wait_obs(2, 1'b0, 4);
    // clocked mode with the internal clock drives the pin
    wr_reg(OFS_MODE, 8'h80); wait_obs(2, 1'b1, 4);
    wr_reg(OFS_CTRL, 8'h02); wait_obs(2, 1'b0, 4);
  endtask
  task automatic t_rx;
    wr_reg(OFS_CTRL, 8'h02); wr_reg(OFS_MODE, 8'h00);
    wr_reg(OFS_CTRL, 8'h52); wait_obs(1, 1'b1, 4);
    far.send({2'b11, 8'h3C, 1'b0}, 11); wait_obs(6, 1'b1, 100);
    // receive off: the full flag keeps its value
    wr_reg(OFS_CTRL, 8'h40); rd_reg(OFS_STATUS); check(rv[6], 1'b1);
    wait_obs(1, 1'b0, 4);
    rd_reg(OFS_RXHOLD); check(rv, 8'h3C);
    wait_obs(6, 1'b0, 4);
  endtask
  task automatic t_mp;
    wr_reg(OFS_CTRL, 8'h02); wr_reg(OFS_MODE, 8'h04);
    wr_reg(OFS_CTRL, 8'h5A);
    far.send({2'b10, 8'h11, 1'b0}, 11);
    rd_reg(OFS_STATUS); check(rv[6], 1'b0);
    far.send({2'b11, 8'h22, 1'b0}, 11); wait_obs(6, 1'b1, 100);
    rd_reg(OFS_CTRL); check(rv, 8'h52);
    rd_reg(OFS_STATUS); check(rv[1], 1'b1);
    rd_reg(OFS_RXHOLD); check(rv, 8'h22);
    // a zero stop bit is a framing error, raised on the error request
    wr_reg(OFS_MODE, 8'h00); far.send({2'b10, 8'h33, 1'b0}, 11);
    wait_obs(5, 1'b1, 100);
    rd_reg(OFS_STATUS); check(rv[4], 1'b1);
    wr_reg(OFS_STATUS, 8'h00); wait_obs(5, 1'b0, 4);
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    t_reset; t_rw; t_irq; t_tx; t_clk; t_rx; t_mp;
    end_sim;
  end
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_errors++;
    end_sim;
  end
endmodule
